// ===== sfrm_pkg.sv
// Package: addresses, reset values, bit positions and vectors of the special register bank.
package sfrm_pkg;
    localparam logic [7:0] ADDR_PORT0 = 8'h80;
    localparam logic [7:0] ADDR_STACK = 8'h81;
    localparam logic [7:0] ADDR_TPLOW = 8'h82;
    localparam logic [7:0] ADDR_TPHIGH = 8'h83;
    localparam logic [7:0] ADDR_TCTRL = 8'h88;
    localparam logic [7:0] ADDR_TMODE = 8'h89;
    localparam logic [7:0] ADDR_T0LOW = 8'h8a;
    localparam logic [7:0] ADDR_T1LOW = 8'h8b;
    localparam logic [7:0] ADDR_T0HIGH = 8'h8c;
    localparam logic [7:0] ADDR_T1HIGH = 8'h8d;
    localparam logic [7:0] ADDR_PORT1 = 8'h90;
    localparam logic [7:0] ADDR_SCTRL = 8'h98;
    localparam logic [7:0] ADDR_SDATA = 8'h99;
    localparam logic [7:0] ADDR_PORT2 = 8'ha0;
    localparam logic [7:0] ADDR_IEMASK = 8'ha8;
    localparam logic [7:0] ADDR_PORT3 = 8'hb0;
    localparam logic [7:0] ADDR_ILEVEL = 8'hb8;
    localparam logic [7:0] ADDR_PSTAT = 8'hd0;
    localparam logic [7:0] ADDR_RESULT = 8'he0;
    localparam logic [7:0] ADDR_MULAUX = 8'hf0;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_PORT = 8'hff;
    localparam logic [7:0] RST_STACK = 8'h07;
    localparam logic [15:0] RST_PC = 16'h0000;
    localparam int TCTRL_T0RUN = 4;
    localparam int TCTRL_T0OVF = 5;
    localparam int TCTRL_T1RUN = 6;
    localparam int TCTRL_T1OVF = 7;
    localparam int TCTRL_IE0 = 1;
    localparam int TCTRL_IE1 = 3;
    localparam int SCTRL_TXDONE = 1;
    localparam int SCTRL_RXDONE = 0;
    localparam int IEMASK_ALL = 7;
    localparam int PSTAT_BANKLO = 3;
    localparam int PSTAT_BANKHI = 4;
    localparam int NUM_SRC = 5;
    localparam logic [15:0] VEC_EXT0 = 16'h0003;
    localparam logic [15:0] VEC_TIM0 = 16'h000b;
    localparam logic [15:0] VEC_EXT1 = 16'h0013;
    localparam logic [15:0] VEC_TIM1 = 16'h001b;
    localparam logic [15:0] VEC_SER = 16'h0023;
    localparam logic [3:0] TX_BITS = 4'ha;
    localparam logic [3:0] TIMER_MODE_NONE = 4'h0;

    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic bitOp;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic bitVal;
    } sfrm_bus_t;

    typedef enum logic [1:0] {
        SFRM_IDLE = 2'b00,
        SFRM_WAIT = 2'b01,
        SFRM_CALL = 2'b10
    } sfrm_irq_state_t;
endpackage

// ===== sfrm_sfr_bank.sv
// Special register bank: byte and bit access, ports, timers, serial transmit, interrupt entry.
`timescale 1ns/1ps
//
// Contract
// (RULE1) Control flags reachable by bit and byte.
// (RULE2) Timer control bit 4 starts first timer.
// (RULE3) Two timers, 16-bit counters, mode and control.
// (RULE4) Four port latches, byte and bit access.
// (RULE5) Ports 0/2 carry external address, data; the code drives only the address, no data.
// (RULE6) Port 1 is plain bidirectional I/O.
// (RULE7) Port 3 carries interrupts, timer, strobes, serial; the code uses only pins 2/3 as interrupts and pin 1 as serial out.
// (RULE8) Writing serial buffer starts transmission.
// (RULE9) Serial port is UART, bit-addressable control.
// (RULE10) Source interrupts only when enabled.
// (RULE11) Interrupt waits for instruction end.
// (RULE12) Accept blocks equal/lower, calls vector.
// (RULE13) Return-from-interrupt re-enables blocked levels.
// (RULE14) Vectors 00,03,0B,13,1B,23 hex.
// (RULE15) Two levels; high preempts low only.
// (RULE16) Core registers zero, ports ones, stack 07.
// (RULE17) Pointer and timer counters clear to zero.
// (RULE18) Program counter clears to zero.
// (RULE19) Two bank bits select register bank.
// (RULE20) Stack pointer increments before push.
// (RULE21) Same level: lowest vector wins.
module sfrm_sfr_bank (
    input wire logic sys_clk,
    input wire logic reset,
    input wire sfrm_pkg::sfrm_bus_t busReq,
    input wire logic pushStrobe,
    input wire logic instrEnd,
    input wire logic retiStrobe,
    input wire logic extMemEn,
    input wire logic [15:0] extAddr,
    input wire logic [7:0] port0In,
    input wire logic [7:0] port1In,
    input wire logic [7:0] port2In,
    input wire logic [7:0] port3In,
    output logic [7:0] rdata,
    output logic [15:0] progCounter,
    output logic [7:0] stackTop,
    output logic [1:0] activeBank,
    output logic irqCall,
    output logic [15:0] irqVector,
    output logic [7:0] port0Out,
    output logic [7:0] port0Oe,
    output logic [7:0] port1Out,
    output logic [7:0] port2Out,
    output logic [7:0] port3Out,
    output logic serialTx
);
    logic [7:0] p0_reg, p1_reg, p2_reg, p3_reg, sp_reg, dpl_reg, dph_reg;
    logic [7:0] timer_control_reg, timer_mode_select_reg, serial_control_reg, serial_data_buffer_reg, ie_reg, ip_reg, psw_reg, acc_reg, b_reg;
    logic [15:0] t0_reg, t1_reg, pc_reg, vec_reg;
    logic [9:0] txShift_reg;
    logic [3:0] txCount_reg;
    logic [1:0] inSvc_reg;
    logic call_reg;
    logic [7:0] rdata_reg, p0Oe_reg;
    logic [7:0] p0Out_reg, p2Out_reg, p3Out_reg;
    logic [7:0] p3Prev_reg;
    sfrm_pkg::sfrm_irq_state_t st_reg, st_next;

    function automatic logic [7:0] bitMerge(input logic [7:0] cur, input sfrm_pkg::sfrm_bus_t r);
        logic [7:0] v;
        v = cur;
        if (r.bitOp) begin
            v[r.wdata[2:0]] = r.bitVal;
        end else begin
            v = r.wdata;
        end
        return v;
    endfunction

    wire wr = busReq.wrEn;
    wire [7:0] wa = busReq.addr;
    wire t0Run = timer_control_reg[sfrm_pkg::TCTRL_T0RUN];
    wire t1Run = timer_control_reg[sfrm_pkg::TCTRL_T1RUN];
    wire t0Ovf = t0Run && (t0_reg == 16'hffff);
    wire t1Ovf = t1Run && (t1_reg == 16'hffff);
    wire ext0Edge = p3Prev_reg[2] && !port3In[2];
    wire ext1Edge = p3Prev_reg[3] && !port3In[3];
    wire txBusy = (txCount_reg != 4'h0);
    wire txFinish = (txCount_reg == 4'h1);
    wire sbufWrite = wr && (wa == sfrm_pkg::ADDR_SDATA);
    wire [4:0] srcPend = {serial_control_reg[sfrm_pkg::SCTRL_TXDONE] | serial_control_reg[sfrm_pkg::SCTRL_RXDONE],
        timer_control_reg[sfrm_pkg::TCTRL_T1OVF], timer_control_reg[sfrm_pkg::TCTRL_IE1],
        timer_control_reg[sfrm_pkg::TCTRL_T0OVF], timer_control_reg[sfrm_pkg::TCTRL_IE0]};
    wire [4:0] srcEn = srcPend & ie_reg[4:0] & {5{ie_reg[sfrm_pkg::IEMASK_ALL]}}; // RULE10
    wire [4:0] hiReq = srcEn & ip_reg[4:0];
    wire [4:0] loReq = srcEn & ~ip_reg[4:0];
    wire hiOk = |hiReq && !inSvc_reg[1]; // RULE15
    wire loOk = |loReq && (inSvc_reg == 2'b00); // RULE15
    wire [4:0] pick = hiOk ? hiReq : loReq;
    logic [15:0] pickVec;
    logic pickHi;

    always_comb begin
        pickHi = hiOk;
        // Lowest index is lowest vector, so scanning upward gives fixed order.
        if (pick[0]) begin
            pickVec = sfrm_pkg::VEC_EXT0; // RULE21
        end else if (pick[1]) begin
            pickVec = sfrm_pkg::VEC_TIM0;
        end else if (pick[2]) begin
            pickVec = sfrm_pkg::VEC_EXT1;
        end else if (pick[3]) begin
            pickVec = sfrm_pkg::VEC_TIM1;
        end else begin
            pickVec = sfrm_pkg::VEC_SER; // RULE14
        end
    end

    always_comb begin
        st_next = st_reg;
        case (st_reg)
            sfrm_pkg::SFRM_IDLE: begin
                if (hiOk || loOk) begin
                    st_next = sfrm_pkg::SFRM_WAIT;
                end
            end
            sfrm_pkg::SFRM_WAIT: begin
                if (instrEnd) begin
                    st_next = sfrm_pkg::SFRM_CALL; // RULE11
                end
            end
            sfrm_pkg::SFRM_CALL: st_next = sfrm_pkg::SFRM_IDLE;
            default: st_next = sfrm_pkg::SFRM_IDLE;
        endcase
    end

    wire accept = (st_reg == sfrm_pkg::SFRM_WAIT) && instrEnd && (hiOk || loOk);

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_reg <= sfrm_pkg::SFRM_IDLE;
            inSvc_reg <= 2'b00;
            call_reg <= 1'b0;
            vec_reg <= sfrm_pkg::RST_PC;
            pc_reg <= sfrm_pkg::RST_PC; // RULE18
        end else begin
            st_reg <= accept ? sfrm_pkg::SFRM_CALL : (st_next == sfrm_pkg::SFRM_CALL ? sfrm_pkg::SFRM_IDLE : st_next);
            call_reg <= accept;
            if (accept) begin
                vec_reg <= pickVec; // RULE12
                pc_reg <= pickVec;
                inSvc_reg <= pickHi ? {1'b1, inSvc_reg[0]} : 2'b01; // RULE12
            end else if (retiStrobe) begin
                // The highest active level ends first, lower nested level stays blocked.
                inSvc_reg <= inSvc_reg[1] ? {1'b0, inSvc_reg[0]} : 2'b00; // RULE13
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            p0_reg <= sfrm_pkg::RST_PORT; // RULE16
            p1_reg <= sfrm_pkg::RST_PORT;
            p2_reg <= sfrm_pkg::RST_PORT;
            p3_reg <= sfrm_pkg::RST_PORT;
            sp_reg <= sfrm_pkg::RST_STACK;
            dpl_reg <= sfrm_pkg::RST_ZERO; // RULE17
            dph_reg <= sfrm_pkg::RST_ZERO;
            timer_mode_select_reg <= sfrm_pkg::RST_ZERO;
            ie_reg <= sfrm_pkg::RST_ZERO;
            ip_reg <= sfrm_pkg::RST_ZERO;
            psw_reg <= sfrm_pkg::RST_ZERO;
            acc_reg <= sfrm_pkg::RST_ZERO;
            b_reg <= sfrm_pkg::RST_ZERO;
        end else begin
            if (wr && wa == sfrm_pkg::ADDR_PORT0) p0_reg <= bitMerge(p0_reg, busReq); // RULE4
            if (wr && wa == sfrm_pkg::ADDR_PORT1) p1_reg <= bitMerge(p1_reg, busReq);
            if (wr && wa == sfrm_pkg::ADDR_PORT2) p2_reg <= bitMerge(p2_reg, busReq);
            if (wr && wa == sfrm_pkg::ADDR_PORT3) p3_reg <= bitMerge(p3_reg, busReq);
            if (wr && wa == sfrm_pkg::ADDR_STACK) begin
                sp_reg <= busReq.wdata;
            end else if (pushStrobe) begin
                sp_reg <= sp_reg + 8'h01; // RULE20
            end
            if (wr && wa == sfrm_pkg::ADDR_TPLOW) dpl_reg <= busReq.wdata;
            if (wr && wa == sfrm_pkg::ADDR_TPHIGH) dph_reg <= busReq.wdata;
            if (wr && wa == sfrm_pkg::ADDR_TMODE) timer_mode_select_reg <= busReq.wdata;
            if (wr && wa == sfrm_pkg::ADDR_IEMASK) ie_reg <= bitMerge(ie_reg, busReq); // RULE1
            if (wr && wa == sfrm_pkg::ADDR_ILEVEL) ip_reg <= bitMerge(ip_reg, busReq);
            if (wr && wa == sfrm_pkg::ADDR_PSTAT) psw_reg <= bitMerge(psw_reg, busReq); // RULE19
            if (wr && wa == sfrm_pkg::ADDR_RESULT) acc_reg <= bitMerge(acc_reg, busReq);
            if (wr && wa == sfrm_pkg::ADDR_MULAUX) b_reg <= bitMerge(b_reg, busReq);
        end
    end

    // Timer control: software writes first, hardware flag sets win over a clear.
    logic [7:0] tconWr;
    assign tconWr = (wr && wa == sfrm_pkg::ADDR_TCTRL) ? bitMerge(timer_control_reg, busReq) : timer_control_reg; // RULE1 RULE2
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            timer_control_reg <= sfrm_pkg::RST_ZERO;
            t0_reg <= 16'h0000;
            t1_reg <= 16'h0000;
            p3Prev_reg <= sfrm_pkg::RST_PORT;
        end else begin
            p3Prev_reg <= port3In;
            timer_control_reg <= tconWr | {t1Ovf, 1'b0, t0Ovf, 1'b0, ext1Edge, 1'b0, ext0Edge, 1'b0}; // RULE7
            if (wr && wa == sfrm_pkg::ADDR_T0LOW) t0_reg[7:0] <= busReq.wdata;
            else if (wr && wa == sfrm_pkg::ADDR_T0HIGH) t0_reg[15:8] <= busReq.wdata;
            else if (t0Run) t0_reg <= t0_reg + 16'h0001; // RULE3
            if (wr && wa == sfrm_pkg::ADDR_T1LOW) t1_reg[7:0] <= busReq.wdata;
            else if (wr && wa == sfrm_pkg::ADDR_T1HIGH) t1_reg[15:8] <= busReq.wdata;
            else if (t1Run) t1_reg <= t1_reg + 16'h0001; // RULE3
        end
    end

    // Simplified UART transmit: one bit per clock, start, eight data, stop.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            serial_control_reg <= sfrm_pkg::RST_ZERO;
            txShift_reg <= 10'h3ff;
            txCount_reg <= 4'h0;
        end else begin
            if (wr && wa == sfrm_pkg::ADDR_SCTRL) begin
                serial_control_reg <= bitMerge(serial_control_reg, busReq) | {6'h00, txFinish, 1'b0}; // RULE9
            end else if (txFinish) begin
                serial_control_reg[sfrm_pkg::SCTRL_TXDONE] <= 1'b1;
            end
            if (sbufWrite && !txBusy) begin
                txShift_reg <= {1'b1, busReq.wdata, 1'b0}; // RULE8
                txCount_reg <= sfrm_pkg::TX_BITS;
            end else if (txBusy) begin
                txShift_reg <= {1'b1, txShift_reg[9:1]};
                txCount_reg <= txCount_reg - 4'h1;
            end
        end
    end

    // The receive buffer is not modelled, so the buffer holds the last byte written.
    always_ff @(posedge sys_clk) begin
        if (sbufWrite) serial_data_buffer_reg <= busReq.wdata;
    end

    wire [7:0] byteRead =
        (wa == sfrm_pkg::ADDR_PORT0) ? port0In :
        (wa == sfrm_pkg::ADDR_PORT1) ? port1In :
        (wa == sfrm_pkg::ADDR_PORT2) ? port2In :
        (wa == sfrm_pkg::ADDR_PORT3) ? port3In :
        (wa == sfrm_pkg::ADDR_STACK) ? sp_reg :
        (wa == sfrm_pkg::ADDR_TPLOW) ? dpl_reg :
        (wa == sfrm_pkg::ADDR_TPHIGH) ? dph_reg :
        (wa == sfrm_pkg::ADDR_TCTRL) ? timer_control_reg :
        (wa == sfrm_pkg::ADDR_TMODE) ? timer_mode_select_reg :
        (wa == sfrm_pkg::ADDR_T0LOW) ? t0_reg[7:0] :
        (wa == sfrm_pkg::ADDR_T1LOW) ? t1_reg[7:0] :
        (wa == sfrm_pkg::ADDR_T0HIGH) ? t0_reg[15:8] :
        (wa == sfrm_pkg::ADDR_T1HIGH) ? t1_reg[15:8] :
        (wa == sfrm_pkg::ADDR_SCTRL) ? serial_control_reg :
        (wa == sfrm_pkg::ADDR_SDATA) ? serial_data_buffer_reg :
        (wa == sfrm_pkg::ADDR_IEMASK) ? ie_reg :
        (wa == sfrm_pkg::ADDR_ILEVEL) ? ip_reg :
        (wa == sfrm_pkg::ADDR_PSTAT) ? psw_reg :
        (wa == sfrm_pkg::ADDR_RESULT) ? acc_reg :
        (wa == sfrm_pkg::ADDR_MULAUX) ? b_reg : 8'h00;
    wire [7:0] readVal = busReq.bitOp ? {7'h00, byteRead[busReq.wdata[2:0]]} : byteRead; // RULE1

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rdata_reg <= 8'h00;
            p0Oe_reg <= 8'h00;
        end else begin
            if (busReq.rdEn) rdata_reg <= readVal;
            p0Oe_reg <= extMemEn ? 8'hff : ~p0_reg; // RULE5
        end
    end

    // Pin drivers are registered so that no pin glitches while the address mux settles.
    // The cost is one cycle of latency between the external address and the pins.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            p0Out_reg <= sfrm_pkg::RST_PORT;
            p2Out_reg <= sfrm_pkg::RST_PORT;
            p3Out_reg <= sfrm_pkg::RST_PORT;
        end else begin
            p0Out_reg <= extMemEn ? extAddr[7:0] : p0_reg; // RULE5
            p2Out_reg <= extMemEn ? extAddr[15:8] : p2_reg; // RULE5
            p3Out_reg <= {p3_reg[7:2], p3_reg[1] & txShift_reg[0], p3_reg[0]}; // RULE7
        end
    end

    assign rdata = rdata_reg;
    assign progCounter = pc_reg;
    assign stackTop = sp_reg;
    assign activeBank = {psw_reg[sfrm_pkg::PSTAT_BANKHI], psw_reg[sfrm_pkg::PSTAT_BANKLO]}; // RULE19
    assign irqCall = call_reg;
    assign irqVector = vec_reg;
    assign port0Out = p0Out_reg; // RULE5
    assign port0Oe = p0Oe_reg;
    assign port1Out = p1_reg; // RULE6
    assign port2Out = p2Out_reg; // RULE5
    assign port3Out = p3Out_reg; // RULE7
    assign serialTx = txShift_reg[0];

    rst_state_a: assert property (@(posedge sys_clk) $fell(reset) |-> sp_reg == 8'h07 && p1_reg == 8'hff) // RULE16
        else $error("Reset values wrong");
    pc_zero_a: assert property (@(posedge sys_clk) $fell(reset) |-> pc_reg == 16'h0000 && t0_reg == 16'h0000) // RULE17
        else $error("Counters not cleared");
    push_inc_a: assert property (@(posedge sys_clk) disable iff (reset)
        pushStrobe && !(wr && wa == sfrm_pkg::ADDR_STACK) |=> sp_reg == $past(sp_reg) + 8'h01) // RULE20
        else $error("Stack not incremented");
    run_count_a: assert property (@(posedge sys_clk) disable iff (reset)
        t0Run && !(wr && (wa == sfrm_pkg::ADDR_T0LOW || wa == sfrm_pkg::ADDR_T0HIGH)) |=> t0_reg == $past(t0_reg) + 16'h0001) // RULE2
        else $error("Timer not counting");
    masked_irq_a: assert property (@(posedge sys_clk) disable iff (reset)
        accept |-> ie_reg[sfrm_pkg::IEMASK_ALL]) // RULE10
        else $error("Masked interrupt taken");
    wait_end_a: assert property (@(posedge sys_clk) disable iff (reset) irqCall |-> $past(instrEnd)) // RULE11
        else $error("Interrupt before instruction end");
    no_lo_pre_a: assert property (@(posedge sys_clk) disable iff (reset)
        accept && inSvc_reg != 2'b00 |-> pickHi && !inSvc_reg[1]) // RULE15
        else $error("Illegal preemption");
    vec_ok_a: assert property (@(posedge sys_clk) disable iff (reset)
        irqCall |-> irqVector inside {16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023}) // RULE14
        else $error("Bad vector");
    tx_start_a: assert property (@(posedge sys_clk) disable iff (reset)
        sbufWrite && !txBusy |=> serialTx == 1'b0 ##1 serialTx == $past(busReq.wdata[0], 2)) // RULE8
        else $error("Transmit not started");
    bank_sel_a: assert property (@(posedge sys_clk) activeBank == psw_reg[4:3]) // RULE19
        else $error("Bank select mismatch");
    ovf_flag_a: assert property (@(posedge sys_clk) disable iff (reset)
        t0Ovf |=> timer_control_reg[sfrm_pkg::TCTRL_T0OVF]) // RULE3
        else $error("Overflow flag lost");
    ext_addr_a: assert property (@(posedge sys_clk) disable iff (reset)
        extMemEn |=> port2Out == $past(extAddr[15:8]) && port0Out == $past(extAddr[7:0])) // RULE5
        else $error("External address not on ports");
    return_from_interrupt_clear_a: assert property (@(posedge sys_clk) disable iff (reset)
        retiStrobe && !accept && !inSvc_reg[1] |=> inSvc_reg == 2'b00) // RULE13
        else $error("Return did not unblock");

    irq_cov_c: cover property (@(posedge sys_clk) irqCall);
    nest_cov_c: cover property (@(posedge sys_clk) inSvc_reg == 2'b11);
    tx_cov_c: cover property (@(posedge sys_clk) txFinish);
endmodule

// ===== sfrm_testbench.sv
// Self-checking testbench for the special register bank.
`timescale 1ns/1ps
module testbench;
    logic sys_clk;
    logic reset;
    sfrm_pkg::sfrm_bus_t busReq;
    logic pushStrobe, instrEnd, retiStrobe, extMemEn;
    logic [15:0] extAddr;
    logic [7:0] port3In;
    logic [7:0] rdata, stackTop, port0Out, port0Oe, port1Out, port2Out, port3Out;
    logic [15:0] progCounter, irqVector;
    logic [1:0] activeBank;
    logic irqCall, serialTx;
    int num_errors = 0;
    int comparisons = 0;

    sfrm_sfr_bank sfrm_sfr_bank_inst (.sys_clk(sys_clk), .reset(reset), .busReq(busReq),
        .pushStrobe(pushStrobe), .instrEnd(instrEnd), .retiStrobe(retiStrobe), .extMemEn(extMemEn),
        .extAddr(extAddr), .port0In(8'hff), .port1In(8'hff), .port2In(8'hff), .port3In(port3In),
        .rdata(rdata), .progCounter(progCounter), .stackTop(stackTop), .activeBank(activeBank),
        .irqCall(irqCall), .irqVector(irqVector), .port0Out(port0Out), .port0Oe(port0Oe),
        .port1Out(port1Out), .port2Out(port2Out), .port3Out(port3Out), .serialTx(serialTx));

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Requests are launched after one edge and released at the edge that takes them.
    task automatic bus(input logic w, input logic b, input logic [7:0] a, input logic [7:0] d, input logic v);
        @(posedge sys_clk);
        busReq <= '{wrEn: w, rdEn: !w, bitOp: b, addr: a, wdata: d, bitVal: v};
        @(posedge sys_clk);
        busReq <= '0;
    endtask

    task automatic rd(input logic b, input logic [7:0] a, input logic [7:0] idx, output logic [7:0] q);
        bus(1'b0, b, a, idx, 1'b0);
        @(posedge sys_clk);
        #1;
        q = rdata;
    endtask

    task automatic expect_irq(input logic exp, input logic [15:0] vec);
        logic seen;
        seen = 1'b0;
        repeat (2) @(posedge sys_clk);
        @(posedge sys_clk) instrEnd <= 1'b1;
        @(posedge sys_clk) instrEnd <= 1'b0;
        repeat (4) begin
            #1;
            if (irqCall === 1'b1) seen = 1'b1;
            @(posedge sys_clk);
        end
        chk("irq taken", {15'h0, exp}, {15'h0, seen});
        if (exp) chk("irq vector", vec, irqVector);
        if (exp) chk("program counter", vec, progCounter);
    endtask

    task automatic test_reset();
        logic [7:0] addrs [19] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d,
            8'h90, 8'h98, 8'ha0, 8'ha8, 8'hb0, 8'hb8, 8'hd0, 8'he0, 8'hf0};
        logic [7:0] q, e;
        foreach (addrs[i]) begin
            rd(1'b0, addrs[i], 8'h00, q);
            e = (addrs[i][3:0] == 4'h0 && addrs[i] < 8'hc0) ? 8'hff : (addrs[i] == 8'h81) ? 8'h07 : 8'h00;
            chk("reset register", {8'h00, e}, {8'h00, q});
        end
        chk("reset pc", 16'h0000, progCounter);
        chk("reset stack", 16'h0007, {8'h00, stackTop});
        chk("reset ports", 16'hffff, {port1Out, port3Out});
        chk("tx idle", 16'h0001, {15'h0, serialTx});
    endtask

    task automatic test_bits_timer();
        logic [7:0] q, a, b;
        bus(1'b1, 1'b1, sfrm_pkg::ADDR_TCTRL, 8'h04, 1'b1);
        rd(1'b0, sfrm_pkg::ADDR_TCTRL, 8'h00, q);
        chk("timer control byte", 16'h0010, {8'h00, q});
        rd(1'b1, sfrm_pkg::ADDR_TCTRL, 8'h04, q);
        chk("run flag bit read", 16'h0001, {15'h0, q[0]});
        rd(1'b0, sfrm_pkg::ADDR_T0LOW, 8'h00, a);
        rd(1'b0, sfrm_pkg::ADDR_T0LOW, 8'h00, b);
        chk("first timer moving", 16'h0001, {15'h0, a !== b});
        rd(1'b0, sfrm_pkg::ADDR_T1LOW, 8'h00, q);
        chk("second timer idle", 16'h0000, {8'h00, q});
        bus(1'b1, 1'b1, sfrm_pkg::ADDR_TCTRL, 8'h04, 1'b0);
        bus(1'b1, 1'b1, sfrm_pkg::ADDR_SCTRL, 8'h04, 1'b1);
        rd(1'b0, sfrm_pkg::ADDR_SCTRL, 8'h00, q);
        chk("serial control byte", 16'h0010, {8'h00, q});
        bus(1'b1, 1'b0, 8'h84, 8'h55, 1'b0);
        rd(1'b0, 8'h84, 8'h00, q);
        chk("unmapped read", 16'h0000, {8'h00, q});
    endtask

    task automatic test_ports();
        bus(1'b1, 1'b0, sfrm_pkg::ADDR_PORT1, 8'h5a, 1'b0);
        bus(1'b1, 1'b1, sfrm_pkg::ADDR_PORT2, 8'h07, 1'b0);
        bus(1'b1, 1'b0, sfrm_pkg::ADDR_PORT0, 8'h0f, 1'b0);
        bus(1'b1, 1'b0, sfrm_pkg::ADDR_PORT3, 8'hfe, 1'b0);
        @(posedge sys_clk);
        #1;
        chk("port one", 16'h005a, {8'h00, port1Out});
        chk("port two bit", 16'h007f, {8'h00, port2Out});
        chk("port zero drive", 16'h0ff0, {port0Out, port0Oe});
        chk("port three", 16'h00fe, {8'h00, port3Out});
        @(posedge sys_clk) begin
            extMemEn <= 1'b1;
            extAddr <= 16'h1234;
        end
        @(posedge sys_clk);
        #1;
        chk("external address", 16'h1234, {port2Out, port0Out});
        chk("external drive", 16'h00ff, {8'h00, port0Oe});
        @(posedge sys_clk) extMemEn <= 1'b0;
    endtask

    task automatic test_stack_bank();
        @(posedge sys_clk) pushStrobe <= 1'b1;
        @(posedge sys_clk) pushStrobe <= 1'b0;
        #1;
        chk("stack after push", 16'h0008, {8'h00, stackTop});
        bus(1'b1, 1'b0, sfrm_pkg::ADDR_PSTAT, 8'h18, 1'b0);
        @(posedge sys_clk);
        #1;
        chk("bank three", 16'h0003, {14'h0, activeBank});
        bus(1'b1, 1'b1, sfrm_pkg::ADDR_PSTAT, 8'h03, 1'b0);
        @(posedge sys_clk);
        #1;
        chk("bank two", 16'h0002, {14'h0, activeBank});
    endtask

    task automatic test_serial();
        logic [7:0] d, q;
        d = 8'ha5;
        bus(1'b1, 1'b0, sfrm_pkg::ADDR_SCTRL, 8'h40, 1'b0);
        bus(1'b1, 1'b0, sfrm_pkg::ADDR_SDATA, d, 1'b0);
        #1;
        chk("start bit", 16'h0000, {15'h0, serialTx});
        for (int i = 0; i < 8; i++) begin
            @(posedge sys_clk);
            #1;
            chk("data bit", {15'h0, d[i]}, {15'h0, serialTx});
        end
        @(posedge sys_clk);
        #1;
        chk("stop bit", 16'h0001, {15'h0, serialTx});
        rd(1'b1, sfrm_pkg::ADDR_SCTRL, 8'h01, q);
        chk("transmit done flag", 16'h0001, {15'h0, q[0]});
    endtask

    task automatic test_irq();
        // Both external lines fall together, so the fixed order decides which is taken.
        @(posedge sys_clk) port3In <= 8'hf3;
        expect_irq(1'b0, 16'h0000);
        bus(1'b1, 1'b0, sfrm_pkg::ADDR_IEMASK, 8'h85, 1'b0);
        expect_irq(1'b1, sfrm_pkg::VEC_EXT0);
        bus(1'b1, 1'b1, sfrm_pkg::ADDR_TCTRL, 8'h01, 1'b0);
        expect_irq(1'b0, 16'h0000);
        @(posedge sys_clk) retiStrobe <= 1'b1;
        @(posedge sys_clk) retiStrobe <= 1'b0;
        expect_irq(1'b1, sfrm_pkg::VEC_EXT1);
        bus(1'b1, 1'b0, sfrm_pkg::ADDR_ILEVEL, 8'h02, 1'b0);
        bus(1'b1, 1'b0, sfrm_pkg::ADDR_T0LOW, 8'hff, 1'b0);
        bus(1'b1, 1'b0, sfrm_pkg::ADDR_T0HIGH, 8'hff, 1'b0);
        bus(1'b1, 1'b1, sfrm_pkg::ADDR_TCTRL, 8'h04, 1'b1);
        bus(1'b1, 1'b0, sfrm_pkg::ADDR_IEMASK, 8'h87, 1'b0);
        expect_irq(1'b1, sfrm_pkg::VEC_TIM0);
    endtask

    task automatic test_done();
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // The whole sequence needs well under a thousand cycles, so this limit only trips on a hang.
    initial begin
        repeat (20000) @(posedge sys_clk);
        num_errors++;
        test_done();
    end

    initial begin
        reset = 1'b1;
        busReq = '0;
        pushStrobe = 1'b0;
        instrEnd = 1'b0;
        retiStrobe = 1'b0;
        extMemEn = 1'b0;
        extAddr = 16'h0000;
        port3In = 8'hff;
        repeat (10) @(posedge sys_clk);
        reset <= 1'b0;
        test_reset();
        test_bits_timer();
        test_ports();
        test_stack_bank();
        test_serial();
        test_irq();
        test_done();
    end
endmodule
